//--- rtl/analog_interface_bus.sv
// Purpose: Router between two digital subsystems and the analog subsystem
// Assumes: Requesters hold req until their done pulse, then drop it
// Notes: Trigger selects and health levels arrive as plain ports
// Operation
// - All four requesters may read converter results
// - Other analog registers: control processor only
// - Control cpu and dma use separate ports
// - Arbitrate all cycles, one at a time
// - Route control trigger sources onto shared triggers
// - Interrupt equals AND of both end-of-conversion
// - All eight to expander, four to dma
// - Triggers start conversions; interrupts announce results
// - Results delivered as 12-bit values
// - Up to four simultaneous cycles resolved
// - Eight selectors pick each trigger source
// - Per-subsystem status: power, clock, propagation health
`timescale 1ns/1ps
`default_nettype none
module analog_interface_bus (
  input wire logic ref_clk,  // 40 MHz clock
  input wire logic arst_n,  // Async reset, active low
  input wire logic clk_en,  // Freezes all state when low
  input wire logic [aib_pkg::N_REQ-1:0] req,  // Request per port, index order in package
  input wire logic [aib_pkg::N_REQ*aib_pkg::ADDR_W-1:0] req_addr,  // Address per port
  input wire logic [aib_pkg::N_REQ-1:0] req_we,  // Write per port
  input wire logic [aib_pkg::N_REQ*aib_pkg::DATA_W-1:0] req_wdata,  // Write data per port
  output logic [aib_pkg::N_REQ-1:0] done,  // One-cycle completion pulse
  output logic [aib_pkg::N_REQ-1:0] err,  // Refused or timed out, with done
  output logic [aib_pkg::N_REQ*aib_pkg::DATA_W-1:0] rdata,  // Read data per port
  output logic ana_req,  // Analog side cycle active
  output logic [aib_pkg::ADDR_W-1:0] ana_addr,  // Analog side address
  output logic ana_we,  // Analog side write
  output logic [aib_pkg::DATA_W-1:0] ana_wdata,  // Analog side write data
  input wire logic ana_ack,  // Analog side cycle complete
  input wire logic [aib_pkg::DATA_W-1:0] ana_rdata,  // Analog side read data
  input wire logic [aib_pkg::N_SRC-1:0] soc_src,  // Control subsystem trigger sources
  input wire logic [aib_pkg::N_TRIG*aib_pkg::SEL_W-1:0] trig_sel,  // Source select per trigger
  output logic [aib_pkg::N_TRIG-1:0] soc_trig,  // Shared converter triggers
  input wire logic [aib_pkg::N_TRIG-1:0] trig_echo,  // Triggers as seen by analog side
  input wire logic [aib_pkg::N_EOC-1:0] eoc_first,  // First converter end of conversion
  input wire logic [aib_pkg::N_EOC-1:0] eoc_second,  // Second converter end of conversion
  output logic [aib_pkg::N_EOC-1:0] master_int,  // Interrupts to master subsystem
  output logic [aib_pkg::N_EOC-1:0] expander_int,  // Interrupts to control interrupt expander
  output logic [aib_pkg::N_DMA_INT-1:0] ctrl_dma_int,  // Interrupts to control dma
  input wire logic ana_pwr_ok,  // Analog side powered
  input wire logic ana_clk_ok,  // Analog clock present
  output logic [aib_pkg::STATUS_W-1:0] master_status,  // Status for master subsystem
  output logic [aib_pkg::STATUS_W-1:0] ctrl_status,  // Status for control subsystem
  output logic bus_err  // Any bus timeout or propagation fault seen
);
  aib_pkg::bus_state_t state;
  logic [aib_pkg::N_REQ-1:0] pend;
  logic [aib_pkg::N_REQ-1:0] gnt;
  logic [aib_pkg::IDX_W-1:0] gnt_idx;
  logic [aib_pkg::IDX_W-1:0] last;
  logic [aib_pkg::IDX_W-1:0] sel;
  logic [aib_pkg::TMO_W-1:0] tmo;
  logic [aib_pkg::N_TRIG-1:0] next_trig;
  logic [aib_pkg::N_EOC-1:0] adc_int;
  logic bus_fault;
  logic trig_fault;
  logic int_fault;
  logic advance;
  logic g_addr_res;
  logic g_legal;

  function automatic logic is_result(input logic [aib_pkg::ADDR_W-1:0] a);
    return a[aib_pkg::ADDR_W-1:aib_pkg::RESULT_TAG_LSB] == aib_pkg::RESULT_TAG;
  endfunction

  function automatic logic pick_src(input logic [aib_pkg::N_SRC-1:0] s, input logic [aib_pkg::SEL_W-1:0] k);
    return (int'(k) < aib_pkg::N_SRC) ? s[k] : 1'b0;
  endfunction

  function automatic logic [aib_pkg::ADDR_W-1:0] addr_of(input logic [aib_pkg::IDX_W-1:0] i,
                                                          input logic [aib_pkg::N_REQ*aib_pkg::ADDR_W-1:0] v);
    return v[i*aib_pkg::ADDR_W +: aib_pkg::ADDR_W];
  endfunction

  // Ports 2 and 3 are the control memory bus and the control dma bus
  assign pend = req & ~done;
  assign g_addr_res = is_result(addr_of(gnt_idx, req_addr));
  // Results open to every port, everything else to the control cpu only
  assign g_legal = g_addr_res || (gnt_idx == aib_pkg::REQ_CTRL_CPU);
  assign advance = (state == aib_pkg::st_idle) && (|pend);

  rr_arbiter i_rr_arbiter (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pend(pend),
    .advance(advance),
    .gnt(gnt),
    .gnt_idx(gnt_idx),
    .last(last)
  );

  // Bus cycle sequencing, one analog cycle at a time
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= aib_pkg::st_idle;
      sel <= '0;
      tmo <= '0;
      done <= '0;
      err <= '0;
      ana_req <= 1'b0;
      ana_addr <= '0;
      ana_we <= 1'b0;
      ana_wdata <= '0;
      bus_fault <= 1'b0;
    end else if (clk_en) begin
      done <= '0;
      err <= '0;
      unique case (state)
        aib_pkg::st_idle: begin
          if (advance) begin
            sel <= gnt_idx;
            if (g_legal) begin
              state <= aib_pkg::st_busy;
              tmo <= '0;
              ana_req <= 1'b1;
              ana_addr <= addr_of(gnt_idx, req_addr);
              ana_we <= req_we[gnt_idx];
              ana_wdata <= req_wdata[gnt_idx*aib_pkg::DATA_W +: aib_pkg::DATA_W];
            end else begin
              done[gnt_idx] <= 1'b1;
              err[gnt_idx] <= 1'b1;
            end
          end
        end
        aib_pkg::st_busy: begin
          if (ana_ack) begin
            state <= aib_pkg::st_idle;
            ana_req <= 1'b0;
            done[sel] <= 1'b1;
          end else if (tmo == aib_pkg::TIMEOUT_CYC - 1'b1) begin
            state <= aib_pkg::st_idle;
            ana_req <= 1'b0;
            done[sel] <= 1'b1;
            err[sel] <= 1'b1;
            bus_fault <= 1'b1;
          end else begin
            tmo <= tmo + 1'b1;
          end
        end
      endcase
    end
  end

  // Read data capture; result reads keep only the converter width
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (clk_en && state == aib_pkg::st_busy && ana_ack && !ana_we) begin
      if (is_result(ana_addr)) begin
        rdata[sel*aib_pkg::DATA_W +: aib_pkg::DATA_W] <= {{(aib_pkg::DATA_W-aib_pkg::RES_W){1'b0}},
                                                           ana_rdata[aib_pkg::RES_W-1:0]};
      end else begin
        rdata[sel*aib_pkg::DATA_W +: aib_pkg::DATA_W] <= ana_rdata;
      end
    end
  end

  // Trigger source selection per shared trigger
  always_comb begin
    next_trig = '0;
    for (int t = 0; t < aib_pkg::N_TRIG; t++) begin
      next_trig[t] = pick_src(soc_src, trig_sel[t*aib_pkg::SEL_W +: aib_pkg::SEL_W]);
    end
  end

  // Registered triggers; only control sources can start a conversion
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      soc_trig <= '0;
    end else if (clk_en) begin
      soc_trig <= next_trig;
    end
  end

  // Combined end-of-conversion interrupts
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_int <= '0;
    end else if (clk_en) begin
      adc_int <= eoc_first & eoc_second;
    end
  end

  // Delivery to both subsystems; dma sees the low four only
  assign master_int = adc_int;
  assign expander_int = adc_int;
  assign ctrl_dma_int = adc_int[aib_pkg::N_DMA_INT-1:0];

  // Sticky trigger and interrupt propagation faults
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_fault <= 1'b0;
      int_fault <= 1'b0;
    end else if (clk_en) begin
      if (trig_echo != soc_trig) begin
        trig_fault <= 1'b1;
      end
      if ((|(eoc_first | eoc_second)) && !ana_clk_ok) begin
        int_fault <= 1'b1;
      end
    end
  end

  // Status words for both subsystems
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_status <= '0;
      ctrl_status <= '0;
      bus_err <= 1'b0;
    end else if (clk_en) begin
      master_status <= {~int_fault, ~trig_fault, ~bus_fault, ana_clk_ok, ana_pwr_ok};
      ctrl_status <= {~int_fault, ~trig_fault, ~bus_fault, ana_clk_ok, ana_pwr_ok};
      bus_err <= bus_fault | trig_fault | int_fault;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_grant_onehot: assert property ($onehot0(gnt) && (!(|pend) || (|gnt)))
    else $error("arbiter grant not one-hot");
  a_protect_regs: assert property ($rose(ana_req) |-> (is_result(ana_addr) || sel == aib_pkg::REQ_CTRL_CPU))
    else $error("protected register reached by wrong requester");
  a_result_open: assert property (clk_en && advance && g_addr_res |=> ana_req && sel == $past(gnt_idx))
    else $error("result read not forwarded");
  a_refuse_err: assert property (clk_en && advance && !g_legal |=> done[sel] && err[sel] && !ana_req)
    else $error("refused access not answered with error");
  a_trig_route: assert property (clk_en |=> soc_trig == $past(next_trig))
    else $error("trigger routing wrong");
  a_eoc_and: assert property (clk_en |=> master_int == $past(eoc_first & eoc_second))
    else $error("combined interrupt wrong");
  a_dma_subset: assert property (ctrl_dma_int == expander_int[aib_pkg::N_DMA_INT-1:0] && expander_int == master_int)
    else $error("interrupt fan-out mismatch");
  a_result_width: assert property (clk_en && state == aib_pkg::st_busy && ana_ack && !ana_we && is_result(ana_addr)
    |=> rdata[sel*aib_pkg::DATA_W+aib_pkg::RES_W +: aib_pkg::DATA_W-aib_pkg::RES_W] == '0)
    else $error("result wider than converter");
  a_wait_bound: assert property (tmo < aib_pkg::TIMEOUT_CYC)
    else $error("analog cycle exceeded timeout");
  a_rr_fair: assert property (advance && (|(pend & ~(aib_pkg::N_REQ'(1) << last))) |-> gnt_idx != last)
    else $error("round-robin regranted last winner");
  a_status_pwr: assert property (clk_en |=> ctrl_status[aib_pkg::ST_PWR] == $past(ana_pwr_ok)
    && master_status == ctrl_status)
    else $error("status does not track power");

  c_result_read: cover property (advance && g_addr_res && gnt_idx == aib_pkg::REQ_MASTER_DMA);
  c_refused: cover property (advance && !g_legal);
  c_four_pending: cover property (&pend);
  c_timeout: cover property (state == aib_pkg::st_busy && tmo == aib_pkg::TIMEOUT_CYC - 1'b1 && !ana_ack);
endmodule  // analog_interface_bus
`default_nettype wire

//--- shared/aib_pkg.sv
// Purpose: Shared constants for the analog interface bus router
// Assumes: One clock domain, ref_clk at 40 MHz
// Notes: Requester index order is master cpu, master dma, control cpu, control dma
package aib_pkg;
  localparam int N_REQ = 4;
  localparam int IDX_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int RES_W = 12;
  localparam int N_TRIG = 8;
  localparam int N_SRC = 22;
  localparam int SEL_W = 5;
  localparam int N_EOC = 8;
  localparam int N_DMA_INT = 4;
  // Result registers live where the top address bits equal RESULT_TAG
  localparam int RESULT_TAG_LSB = 5;
  localparam logic [2:0] RESULT_TAG = 3'h0;
  // Requester indices
  localparam logic [1:0] REQ_MASTER_CPU = 2'h0;
  localparam logic [1:0] REQ_MASTER_DMA = 2'h1;
  localparam logic [1:0] REQ_CTRL_CPU = 2'h2;
  localparam logic [1:0] REQ_CTRL_DMA = 2'h3;
  // Analog side answer timeout
  localparam int CLK_MHZ = 40;
  localparam int TIMEOUT_NS = 400;
  localparam int TMO_W = 5;
  localparam logic [TMO_W-1:0] TIMEOUT_CYC = TMO_W'((TIMEOUT_NS * CLK_MHZ) / 1000);
  // Status word layout
  localparam int STATUS_W = 5;
  localparam int ST_PWR = 0;
  localparam int ST_CLK = 1;
  localparam int ST_BUS_OK = 2;
  localparam int ST_TRIG_OK = 3;
  localparam int ST_INT_OK = 4;
  typedef enum logic {st_idle, st_busy} bus_state_t;
endpackage

//--- rtl/rr_arbiter.sv
// Purpose: Round-robin pick among pending bus requesters
// Assumes: Pointer advances only when the caller accepts a grant
// Notes: Grant is combinational from the pending vector
`timescale 1ns/1ps
`default_nettype none
module rr_arbiter (
  input wire logic ref_clk,  // Clock
  input wire logic arst_n,  // Async reset, active low
  input wire logic clk_en,  // Freezes the pointer when low
  input wire logic [aib_pkg::N_REQ-1:0] pend,  // Pending requests
  input wire logic advance,  // Grant accepted this cycle
  output logic [aib_pkg::N_REQ-1:0] gnt,  // One-hot grant
  output logic [aib_pkg::IDX_W-1:0] gnt_idx,  // Index of the grant
  output logic [aib_pkg::IDX_W-1:0] last  // Most recently served index
);
  // Search starts just after the last winner so no port starves
  always_comb begin
    logic [aib_pkg::IDX_W-1:0] cand;
    gnt = '0;
    gnt_idx = '0;
    cand = '0;
    for (int k = aib_pkg::N_REQ; k >= 1; k--) begin
      cand = last + aib_pkg::IDX_W'(k);
      if (pend[cand]) begin
        gnt_idx = cand;
      end
    end
    if (|pend) begin
      gnt[gnt_idx] = 1'b1;
    end
  end

  // Pointer update
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last <= aib_pkg::IDX_W'(aib_pkg::N_REQ - 1);
    end else if (clk_en && advance) begin
      last <= gnt_idx;
    end
  end
endmodule  // rr_arbiter
`default_nettype wire

//--- testbench/analog_side_model.sv
// Purpose: Behavioural analog side: register file, bus answers, trigger echo
// Assumes: One clock; answers after ack_delay waiting cycles unless muted
// Notes: Read data outside the answer cycle shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module analog_side_model (
  input wire logic ref_clk,  // Clock
  input wire logic arst_n,  // Async reset, active low
  input wire logic ana_req,  // Cycle active
  input wire logic [aib_pkg::ADDR_W-1:0] ana_addr,  // Register address
  input wire logic ana_we,  // Write
  input wire logic [aib_pkg::DATA_W-1:0] ana_wdata,  // Write data
  output logic ana_ack,  // Cycle complete
  output logic [aib_pkg::DATA_W-1:0] ana_rdata,  // Read data
  input wire logic [aib_pkg::N_TRIG-1:0] soc_trig,  // Triggers in
  output logic [aib_pkg::N_TRIG-1:0] trig_echo,  // Triggers as seen here
  input wire logic [3:0] ack_delay,  // Waiting cycles before answering
  input wire logic mute,  // Never answer
  input wire logic echo_bad  // Corrupt the trigger echo
);
  logic [15:0] regs [256];
  logic [3:0] wait_cnt;
  logic [15:0] last;
  // Answer one cycle, then drop; registers start at a known pattern
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ana_ack <= 1'b0;
      wait_cnt <= 4'h0;
      last <= 16'h0000;
      for (int i = 0; i < 256; i++) regs[i] <= 16'ha500 | 16'(i);
    end else if (ana_req && !ana_ack && !mute) begin
      if (wait_cnt == ack_delay) begin
        ana_ack <= 1'b1;
        last <= regs[ana_addr];
        if (ana_we) regs[ana_addr] <= ana_wdata;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      ana_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end
  // Stale data is never shown as valid
  assign ana_rdata = ana_ack ? last : ~last;
  assign trig_echo = soc_trig ^ {aib_pkg::N_TRIG{echo_bad}};
endmodule  // analog_side_model
`default_nettype wire

//--- testbench/tb_analog_interface_bus.sv
// Purpose: Self-checking bench for the analog interface bus router
// Assumes: Analog side model answers cycles and echoes triggers
// Notes: Inputs change on the falling edge; status faults are sticky, so the timeout runs last
`timescale 1ns/1ps
`default_nettype none
module tb_analog_interface_bus;
  logic ref_clk, arst_n, clk_en, ana_req, ana_we, ana_ack, mute, echo_bad, ana_pwr_ok, ana_clk_ok, bus_err;
  logic [3:0] req, req_we, done, err, ack_delay, ctrl_dma_int;
  logic [31:0] req_addr;
  logic [63:0] req_wdata, rdata;
  logic [7:0] ana_addr, soc_trig, trig_echo, eoc_first, eoc_second, master_int, expander_int;
  logic [15:0] ana_wdata, ana_rdata;
  logic [21:0] soc_src;
  logic [39:0] trig_sel;
  logic [4:0] master_status, ctrl_status;
  int n_errors, comparisons, ana_cyc;

  // Clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Count analog cycles to prove refusals never reach the far side
  always @(posedge ref_clk) if (ana_req === 1'b1) ana_cyc++;

  analog_interface_bus i_analog_interface_bus (.ref_clk, .arst_n, .clk_en, .req, .req_addr, .req_we,
    .req_wdata, .done, .err, .rdata, .ana_req, .ana_addr, .ana_we, .ana_wdata, .ana_ack, .ana_rdata,
    .soc_src, .trig_sel, .soc_trig, .trig_echo, .eoc_first, .eoc_second, .master_int, .expander_int,
    .ctrl_dma_int, .ana_pwr_ok, .ana_clk_ok, .master_status, .ctrl_status, .bus_err);
  analog_side_model i_analog_side_model (.ref_clk, .arst_n, .ana_req, .ana_addr, .ana_we, .ana_wdata,
    .ana_ack, .ana_rdata, .soc_trig, .trig_echo, .ack_delay, .mute, .echo_bad);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("mismatch at %0t: %s timed out", $time, what);
    close_out();
  endtask
  // One bus cycle on port p: hold the request until done, judge err and read data
  task automatic xfer(input int p, input logic [7:0] a, input logic w, input logic [15:0] wd,
                      input logic [15:0] exp, input logic exp_err);
    int n;
    req[p] = 1'b1;
    req_addr[8*p+:8] = a;
    req_we[p] = w;
    req_wdata[16*p+:16] = wd;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (done[p] !== 1'b1 && n < 40);
    if (n >= 40) hang("bus cycle");
    chk({15'h0, err[p]}, {15'h0, exp_err}, "error flag");
    if (!w && !exp_err) chk(rdata[16*p+:16], exp, "read data");
    req[p] = 1'b0;
    // Let an edge pass so a following call never re-raises req in this time step
    @(negedge ref_clk);
  endtask

  task automatic t_status;
    @(negedge ref_clk);
    chk({11'h0, master_status}, 16'h001f, "master status");
    ana_pwr_ok = 1'b0;
    @(negedge ref_clk);
    chk({11'h0, ctrl_status}, 16'h001e, "ctrl status no power");
    ana_pwr_ok = 1'b1;
    ana_clk_ok = 1'b0;
    @(negedge ref_clk);
    chk({11'h0, master_status}, 16'h001d, "master status no clock");
    ana_clk_ok = 1'b1;
    @(negedge ref_clk);
    $display("test status levels done");
  endtask
  task automatic t_reads;
    for (int p = 0; p < 4; p++) xfer(p, 8'(3 + p), 1'b0, 16'h0, 16'(16'h0503 + p), 1'b0);
    ack_delay = 4'h3;
    xfer(1, 8'h1f, 1'b0, 16'h0, 16'h051f, 1'b0);
    ack_delay = 4'h0;
    xfer(2, 8'h07, 1'b1, 16'hf123, 16'h0, 1'b0);
    xfer(3, 8'h07, 1'b0, 16'h0, 16'h0123, 1'b0);
    $display("test result reads done");
  endtask
  task automatic t_guard;
    ana_cyc = 0;
    for (int p = 0; p < 4; p++) if (p != 2) xfer(p, 8'h45, 1'b1, 16'hdead, 16'h0, 1'b1);
    xfer(0, 8'he0, 1'b0, 16'h0, 16'h0, 1'b1);
    chk(16'(ana_cyc), 16'h0000, "analog cycles on refusal");
    xfer(2, 8'h45, 1'b0, 16'h0, 16'ha545, 1'b0);
    xfer(2, 8'h45, 1'b1, 16'hbeef, 16'h0, 1'b0);
    xfer(2, 8'h45, 1'b0, 16'h0, 16'hbeef, 1'b0);
    $display("test access guard done");
  endtask
  task automatic t_arbit;
    int n, prev, cnt, idx;
    for (int i = 0; i < 4; i++) begin
      req[i] = 1'b1;
      req_addr[8*i+:8] = 8'(8'h10 + i);
      req_we[i] = 1'b0;
    end
    prev = -1;
    cnt = 0;
    n = 0;
    while (cnt < 4 && n < 200) begin
      @(negedge ref_clk);
      n++;
      if (done !== 4'h0) begin
        chk(16'($countones(done)), 16'h0001, "one grant at a time");
        for (int i = 0; i < 4; i++) if (done[i] === 1'b1) idx = i;
        if (prev >= 0) chk(16'(idx), 16'((prev + 1) % 4), "round robin order");
        chk(rdata[16*idx+:16], 16'(16'h0510 + idx), "contended read");
        req[idx] = 1'b0;
        prev = idx;
        cnt++;
      end
    end
    if (cnt < 4) hang("contention");
    $display("test arbitration done");
  endtask
  task automatic t_trig;
    logic [7:0] exp;
    for (int t = 0; t < 8; t++) trig_sel[5*t+:5] = 5'(3 * t);
    for (int s = 0; s < 22; s++) begin
      soc_src = 22'h1 << s;
      @(negedge ref_clk);
      for (int t = 0; t < 8; t++) exp[t] = (3 * t == s);
      chk({8'h0, soc_trig}, {8'h0, exp}, "trigger route");
    end
    trig_sel[9:0] = {5'd31, 5'd22};
    soc_src = 22'h3fffff;
    @(negedge ref_clk);
    chk({8'h0, soc_trig}, 16'h00fc, "out of range select");
    soc_src = 22'h0;
    $display("test triggers done");
  endtask
  task automatic t_ints;
    logic [15:0] pats [5] = '{16'hff00, 16'h0ff0, 16'ha5ff, 16'hffff, 16'h3c5a};
    for (int k = 0; k < 5; k++) begin
      {eoc_first, eoc_second} = pats[k];
      @(negedge ref_clk);
      chk({8'h0, master_int}, {8'h0, pats[k][15:8] & pats[k][7:0]}, "master int");
      chk({8'h0, expander_int}, {8'h0, pats[k][15:8] & pats[k][7:0]}, "expander int");
      chk({12'h0, ctrl_dma_int}, {12'h0, pats[k][11:8] & pats[k][3:0]}, "dma int");
    end
    // Clock enable low must freeze the combined interrupts
    clk_en = 1'b0;
    {eoc_first, eoc_second} = 16'hffff;
    @(negedge ref_clk);
    chk({8'h0, master_int}, 16'h0018, "frozen int");
    clk_en = 1'b1;
    @(negedge ref_clk);
    chk({8'h0, master_int}, 16'h00ff, "int after enable");
    {eoc_first, eoc_second} = 16'h0;
    $display("test interrupts done");
  endtask
  task automatic t_timeout;
    mute = 1'b1;
    xfer(2, 8'h50, 1'b0, 16'h0, 16'h0, 1'b1);
    mute = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({11'h0, ctrl_status}, 16'h001b, "status after timeout");
    chk({15'h0, bus_err}, 16'h0001, "fault flag");
    // End of conversion while the clock is missing, then a broken trigger echo
    ana_clk_ok = 1'b0;
    eoc_first = 8'h01;
    @(negedge ref_clk);
    ana_clk_ok = 1'b1;
    eoc_first = 8'h00;
    echo_bad = 1'b1;
    @(negedge ref_clk);
    echo_bad = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({11'h0, ctrl_status}, 16'h0003, "ctrl status after faults");
    chk({11'h0, master_status}, 16'h0003, "master status after faults");
    $display("test timeout done");
  endtask

  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    {req, req_we, req_addr, req_wdata, mute, echo_bad, ack_delay} = '0;
    {soc_src, trig_sel, eoc_first, eoc_second} = '0;
    ana_pwr_ok = 1'b1;
    ana_clk_ok = 1'b1;
    n_errors = 0;
    comparisons = 0;
    ana_cyc = 0;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    t_status();
    t_reads();
    t_guard();
    t_arbit();
    t_trig();
    t_ints();
    t_timeout();
    close_out();
  end
endmodule  // tb_analog_interface_bus
`default_nettype wire
